/* rtl/dma_regs_defines.svh */
/*
  Register offsets, field positions, reset values and widths of the two-channel DMA register set.
  Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef DMA_REGS_DEFINES_SVH
`define DMA_REGS_DEFINES_SVH

// Register offsets in the CPU I/O space.
`define OFS_DST0_LOW        8'h23
`define OFS_DST0_HIGH       8'h24
`define OFS_DST0_BANK       8'h25
`define OFS_CNT0_LOW        8'h26
`define OFS_CNT0_HIGH       8'h27
`define OFS_MEM1_LOW        8'h28
`define OFS_MEM1_HIGH       8'h29
`define OFS_MEM1_BANK       8'h2A
`define OFS_IO1_LOW         8'h2B
`define OFS_IO1_HIGH        8'h2C
`define OFS_IO1_SELECT      8'h2D
`define OFS_CNT1_LOW        8'h2E
`define OFS_CNT1_HIGH       8'h2F
`define OFS_STATUS          8'h30

// Status register fields.
`define ST_CH1_EN_BIT       7
`define ST_CH0_EN_BIT       6
`define ST_CH1_GUARD_BIT    5
`define ST_CH0_GUARD_BIT    4
`define ST_CH1_IE_BIT       3
`define ST_CH0_IE_BIT       2
`define ST_MAIN_EN_BIT      0

// Widths and fixed values.
`define ADDR_W              20
`define IO_ADDR_W           16
`define COUNT_W             16
`define COUNT_ONE           16'h0001
`define SELECT_RESET        8'h00
`define READ_ZERO           8'h00
`define BANK_LSB            16
`define BANK_W              4
`define SRC_SEL_LSB         16

`endif

/* rtl/dma_regs_pkg.sv */
/*
  Types shared by the DMA register block: request source selection and per-byte address step.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dma_regs_pkg;

  // Request source chosen by address bits 17:16 of channel 0 or select byte bits 1:0 of channel 1.
  typedef enum logic [1:0]
  {
    REQ_EXTERNAL = 2'b00,
    REQ_SERIAL0  = 2'b01,
    REQ_SERIAL1  = 2'b10,
    REQ_UNUSED   = 2'b11
  } req_source_t;

  // Address update applied after each moved byte.
  typedef enum logic [1:0]
  {
    STEP_HOLD = 2'b00,
    STEP_INC  = 2'b01,
    STEP_DEC  = 2'b10,
    STEP_RSVD = 2'b11
  } addr_step_t;

endpackage : dma_regs_pkg

/* rtl/dual_channel_dma_regs_enable.sv */
/*
  Two-channel DMA register set with channel enable, main enable and termination logic.
  Assumes a CPU core on sys_clk that issues one-cycle I/O read and write strobes, a bus sequencer
  that pulses a byte-moved strobe per channel, and a one-cycle NMI pulse, all on sys_clk.
*/
// Function
// R1: Channel 0 I/O request source comes from destination address bits 17:16.
// R2: Channel 0 byte counter is 16 bits and drops by one per moved byte.
// R3: Software loads the exact byte count before starting a transfer.
// R4: Byte counters of both channels have no reset value.
// R5: Channel 1 memory address is 20 bits, source or destination.
// R6: Channel 1 I/O address is 16 bits plus a request select byte.
// R7: Reset clears every bit of the channel 1 request select byte.
// R8: Status bits: enables 7 and 6, guards 5 and 4, irq enables 3 and 2, main 0.
// R9: A channel transfers only while its enable and the main enable are both 1.
// R10: Counter reaching zero clears that channel's enable by hardware.
// R11: Interrupt request while channel enable is 0 and its interrupt enable is 1.
// R12: Software changes a channel enable only when its guard bit is written 0.
// R13: Both guard bits always read as 1.
// R14: Writing enable 1 also sets main enable; writing 0 stops but keeps state.
// R15: NMI clears the main enable until an enable is rewritten with 1.
// R16: Main enable ignores direct writes.
// R17: Reset clears channel enables, interrupt enables and main enable.
// R18: Channel 0 destination address is 20 bits, memory or I/O.
// R19: Address and count registers read back their live values.
`timescale 1ns/10ps
`include "dma_regs_defines.svh"

module dual_channel_dma_regs_enable
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  // CPU I/O register port
  input  wire logic [7:0]               io_addr,
  input  wire logic [7:0]               io_wdata,
  input  wire logic                     io_wr,
  input  wire logic                     io_rd,
  output logic      [7:0]               io_rdata,
  input  wire logic                     nmi_pulse,
  // Request sources
  input  wire logic                     external_request_in,
  input  wire logic                     external_request_in1,
  input  wire logic                     serial0_tx_request,
  input  wire logic                     serial1_tx_request,
  // Bus sequencer handshake
  input  wire logic                     ch0_byte_moved,
  input  wire logic                     ch1_byte_moved,
  input  wire logic [1:0]               ch0_dest_step,
  input  wire logic [1:0]               ch1_memory_step,
  output logic                          ch0_active,
  output logic                          ch1_active,
  output logic                          ch0_transfer_req,
  output logic                          ch1_transfer_req,
  output logic      [`ADDR_W-1:0]       ch0_dest_address,
  output logic      [`ADDR_W-1:0]       ch1_memory_address,
  output logic      [`IO_ADDR_W-1:0]    ch1_io_address,
  output logic      [7:0]               ch1_request_select_byte,
  // Interrupt requests to the CPU
  output logic                          ch0_irq,
  output logic                          ch1_irq
);

  logic [`COUNT_W-1:0] ch0_byte_counter;
  logic [`COUNT_W-1:0] ch1_byte_counter;
  logic                ch0_enable;
  logic                ch1_enable;
  logic                ch0_irq_enable;
  logic                ch1_irq_enable;
  logic                dma_main_enable;
  logic                ext0_meta;
  logic                ext0_sync;
  logic                ext1_meta;
  logic                ext1_sync;
  logic                status_wr;
  logic                ch0_guard_open;
  logic                ch1_guard_open;
  logic                ch0_terminal;
  logic                ch1_terminal;
  logic                ch0_run;
  logic                ch1_run;
  logic [7:0]          next_rdata;

  // Picks one request line by the two-bit source code.
  function automatic logic pick_request(input logic [1:0] sel, input logic ext, input logic s0, input logic s1);
    case (dma_regs_pkg::req_source_t'(sel))
      dma_regs_pkg::REQ_EXTERNAL: pick_request = ext;
      dma_regs_pkg::REQ_SERIAL0:  pick_request = s0;
      dma_regs_pkg::REQ_SERIAL1:  pick_request = s1;
      default:                    pick_request = 1'b0;
    endcase
  endfunction : pick_request

  // Applies the per-byte address step; the reserved code holds the address.
  function automatic logic [`ADDR_W-1:0] step_address(input logic [`ADDR_W-1:0] a, input logic [1:0] step);
    case (dma_regs_pkg::addr_step_t'(step))
      dma_regs_pkg::STEP_INC: step_address = a + `ADDR_W'(1);
      dma_regs_pkg::STEP_DEC: step_address = a - `ADDR_W'(1);
      default:                step_address = a;
    endcase
  endfunction : step_address

  function automatic logic is_write(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
    is_write = wr && (addr == ofs);
  endfunction : is_write

  assign status_wr      = is_write(io_wr, io_addr, `OFS_STATUS);
  assign ch0_guard_open = status_wr && !io_wdata[`ST_CH0_GUARD_BIT]; // R12
  assign ch1_guard_open = status_wr && !io_wdata[`ST_CH1_GUARD_BIT]; // R12
  assign ch0_run        = ch0_enable && dma_main_enable; // R9
  assign ch1_run        = ch1_enable && dma_main_enable; // R9
  // The last byte of a run ends the transfer.
  assign ch0_terminal   = ch0_run && ch0_byte_moved && (ch0_byte_counter == `COUNT_ONE); // R10
  assign ch1_terminal   = ch1_run && ch1_byte_moved && (ch1_byte_counter == `COUNT_ONE); // R10

  // The external request pins are asynchronous and go through two flops first.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext0_meta <= 1'b0;
      ext0_sync <= 1'b0;
      ext1_meta <= 1'b0;
      ext1_sync <= 1'b0;
    end
    else
    begin
      ext0_meta <= external_request_in;
      ext0_sync <= ext0_meta;
      ext1_meta <= external_request_in1;
      ext1_sync <= ext1_meta;
    end
  end

  // Counters have no reset on purpose; software must load them before use.
  always_ff @(posedge sys_clk) // R4
  begin
    if (is_write(io_wr, io_addr, `OFS_CNT0_LOW))
      ch0_byte_counter[7:0] <= io_wdata;
    else if (is_write(io_wr, io_addr, `OFS_CNT0_HIGH))
      ch0_byte_counter[15:8] <= io_wdata;
    else if (ch0_run && ch0_byte_moved)
      ch0_byte_counter <= ch0_byte_counter - `COUNT_ONE; // R2
    if (is_write(io_wr, io_addr, `OFS_CNT1_LOW))
      ch1_byte_counter[7:0] <= io_wdata;
    else if (is_write(io_wr, io_addr, `OFS_CNT1_HIGH))
      ch1_byte_counter[15:8] <= io_wdata;
    else if (ch1_run && ch1_byte_moved)
      ch1_byte_counter <= ch1_byte_counter - `COUNT_ONE;
  end

  // Address registers; a software write wins over the per-byte step.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch0_dest_address   <= '0;
      ch1_memory_address <= '0;
      ch1_io_address     <= '0;
    end
    else
    begin
      if (is_write(io_wr, io_addr, `OFS_DST0_LOW))
        ch0_dest_address[7:0] <= io_wdata; // R18
      else if (is_write(io_wr, io_addr, `OFS_DST0_HIGH))
        ch0_dest_address[15:8] <= io_wdata;
      else if (is_write(io_wr, io_addr, `OFS_DST0_BANK))
        ch0_dest_address[`ADDR_W-1:`BANK_LSB] <= io_wdata[`BANK_W-1:0];
      else if (ch0_run && ch0_byte_moved)
        ch0_dest_address <= step_address(ch0_dest_address, ch0_dest_step); // R19
      if (is_write(io_wr, io_addr, `OFS_MEM1_LOW))
        ch1_memory_address[7:0] <= io_wdata; // R5
      else if (is_write(io_wr, io_addr, `OFS_MEM1_HIGH))
        ch1_memory_address[15:8] <= io_wdata;
      else if (is_write(io_wr, io_addr, `OFS_MEM1_BANK))
        ch1_memory_address[`ADDR_W-1:`BANK_LSB] <= io_wdata[`BANK_W-1:0];
      else if (ch1_run && ch1_byte_moved)
        ch1_memory_address <= step_address(ch1_memory_address, ch1_memory_step); // R19
      if (is_write(io_wr, io_addr, `OFS_IO1_LOW))
        ch1_io_address[7:0] <= io_wdata; // R6
      else if (is_write(io_wr, io_addr, `OFS_IO1_HIGH))
        ch1_io_address[15:8] <= io_wdata;
    end
  end

  // Request select byte of channel 1.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      ch1_request_select_byte <= `SELECT_RESET; // R7
    else if (is_write(io_wr, io_addr, `OFS_IO1_SELECT))
      ch1_request_select_byte <= io_wdata; // R6
  end

  // Channel enables: a software write with its guard bit 0 wins over a same-cycle termination,
  // so a restart written on the last byte is not lost.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch0_enable <= 1'b0; // R17
      ch1_enable <= 1'b0; // R17
    end
    else
    begin
      if (ch0_guard_open)
        ch0_enable <= io_wdata[`ST_CH0_EN_BIT]; // R12 R14
      else if (ch0_terminal)
        ch0_enable <= 1'b0; // R10
      if (ch1_guard_open)
        ch1_enable <= io_wdata[`ST_CH1_EN_BIT]; // R12 R14
      else if (ch1_terminal)
        ch1_enable <= 1'b0; // R10
    end
  end

  // Interrupt enables are plain read/write bits.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch0_irq_enable <= 1'b0; // R17
      ch1_irq_enable <= 1'b0; // R17
    end
    else if (status_wr)
    begin
      ch0_irq_enable <= io_wdata[`ST_CH0_IE_BIT];
      ch1_irq_enable <= io_wdata[`ST_CH1_IE_BIT];
    end
  end

  // Main enable is never written directly; NMI wins over a same-cycle restart so
  // the NMI handler always starts with DMA halted.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      dma_main_enable <= 1'b0; // R17
    else if (nmi_pulse)
      dma_main_enable <= 1'b0; // R15
    else if ((ch0_guard_open && io_wdata[`ST_CH0_EN_BIT]) || (ch1_guard_open && io_wdata[`ST_CH1_EN_BIT]))
      dma_main_enable <= 1'b1; // R14 R15 R16
  end

  // Requests and run flags, registered so outputs come from flops.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch0_active       <= 1'b0;
      ch1_active       <= 1'b0;
      ch0_transfer_req <= 1'b0;
      ch1_transfer_req <= 1'b0;
    end
    else
    begin
      ch0_active       <= ch0_run; // R9
      ch1_active       <= ch1_run; // R9
      ch0_transfer_req <= ch0_run && pick_request(ch0_dest_address[`SRC_SEL_LSB+1:`SRC_SEL_LSB],
                                                  ext0_sync, serial0_tx_request, serial1_tx_request); // R1
      ch1_transfer_req <= ch1_run && pick_request(ch1_request_select_byte[1:0],
                                                  ext1_sync, serial0_tx_request, serial1_tx_request);
    end
  end

  // Termination interrupt requests are levels that follow the enable bits.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch0_irq <= 1'b0;
      ch1_irq <= 1'b0;
    end
    else
    begin
      ch0_irq <= !ch0_enable && ch0_irq_enable; // R11
      ch1_irq <= !ch1_enable && ch1_irq_enable; // R11
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    next_rdata = `READ_ZERO;
    case (io_addr)
      `OFS_DST0_LOW:   next_rdata = ch0_dest_address[7:0]; // R19
      `OFS_DST0_HIGH:  next_rdata = ch0_dest_address[15:8];
      `OFS_DST0_BANK:  next_rdata = {4'h0, ch0_dest_address[`ADDR_W-1:`BANK_LSB]};
      `OFS_CNT0_LOW:   next_rdata = ch0_byte_counter[7:0];
      `OFS_CNT0_HIGH:  next_rdata = ch0_byte_counter[15:8];
      `OFS_MEM1_LOW:   next_rdata = ch1_memory_address[7:0];
      `OFS_MEM1_HIGH:  next_rdata = ch1_memory_address[15:8];
      `OFS_MEM1_BANK:  next_rdata = {4'h0, ch1_memory_address[`ADDR_W-1:`BANK_LSB]};
      `OFS_IO1_LOW:    next_rdata = ch1_io_address[7:0];
      `OFS_IO1_HIGH:   next_rdata = ch1_io_address[15:8];
      `OFS_IO1_SELECT: next_rdata = ch1_request_select_byte;
      `OFS_CNT1_LOW:   next_rdata = ch1_byte_counter[7:0];
      `OFS_CNT1_HIGH:  next_rdata = ch1_byte_counter[15:8];
      `OFS_STATUS:
      begin
        next_rdata[`ST_CH1_EN_BIT]    = ch1_enable; // R8
        next_rdata[`ST_CH0_EN_BIT]    = ch0_enable;
        next_rdata[`ST_CH1_GUARD_BIT] = 1'b1; // R13
        next_rdata[`ST_CH0_GUARD_BIT] = 1'b1; // R13
        next_rdata[`ST_CH1_IE_BIT]    = ch1_irq_enable;
        next_rdata[`ST_CH0_IE_BIT]    = ch0_irq_enable;
        next_rdata[`ST_MAIN_EN_BIT]   = dma_main_enable;
      end
      default:         next_rdata = `READ_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      io_rdata <= `READ_ZERO;
    else if (io_rd)
      io_rdata <= next_rdata;
  end

endmodule : dual_channel_dma_regs_enable

/* tb/dual_channel_dma_regs_enable_asserts.sv */
/*
  Concurrent checks on the ports of the DMA register block.
  Assumes a bind from the bench top and the shared defines header.
*/
`timescale 1ns/10ps
`include "dma_regs_defines.svh"

module dual_channel_dma_regs_enable_asserts
(
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               arst_n,
  // Register port
  input wire logic [7:0]         io_addr,
  input wire logic [7:0]         io_wdata,
  input wire logic               io_wr,
  input wire logic               io_rd,
  input wire logic [7:0]         io_rdata,
  input wire logic               nmi_pulse,
  // Channel outputs
  input wire logic               ch0_active,
  input wire logic               ch1_active,
  input wire logic               ch0_transfer_req,
  input wire logic [`ADDR_W-1:0] ch0_dest_address,
  input wire logic [7:0]         ch1_request_select_byte,
  input wire logic               ch0_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  wire status_wr = io_wr && io_addr == 8'h30;

  guard_reads_a: assert property
    (io_rd && io_addr == 8'h30 |=> io_rdata[5:4] == 2'h3 && !io_rdata[1])
    else $error("guard bits did not read as ones");
  unmapped_read_a: assert property
    (io_rd && (io_addr < 8'h23 || io_addr > 8'h30) |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  select_reset_a: assert property
    ($rose(arst_n) |-> ch1_request_select_byte == 8'h00)
    else $error("request select byte not cleared by reset");
  nmi_halt_a: assert property
    (nmi_pulse |-> ##2 !ch0_active && !ch1_active)
    else $error("channel still active after nmi");
  run_gate_a: assert property
    (ch0_transfer_req |-> ch0_active)
    else $error("transfer request without running channel");
  irq_idle_a: assert property
    (ch0_irq |-> !ch0_active)
    else $error("interrupt raised while channel runs");
  enable_write_a: assert property
    (status_wr && io_wdata[6] && !io_wdata[4] && !nmi_pulse |-> ##2 ch0_active)
    else $error("enable write did not start channel");
  guarded_write_a: assert property
    (status_wr && io_wdata[5:4] == 2'h3 && !ch0_active ##1 !ch0_active |=> !ch0_active)
    else $error("guarded write changed channel state");
  src_unused_a: assert property
    (ch0_transfer_req |-> $past(ch0_dest_address[17:16]) != 2'h3)
    else $error("request from unused source");

  cover property (ch0_irq);
  cover property (nmi_pulse ##2 !ch1_active);
  cover property (status_wr ##2 ch0_active);
endmodule : dual_channel_dma_regs_enable_asserts

/* tb/dma_bus_sequencer_model.sv */
/*
  Bus sequencer model: moves one byte per granted request, every cycle or every fourth.
  Assumes the block's registered transfer requests on the same clock.
*/
`timescale 1ns/10ps

module dma_bus_sequencer_model
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Pace and requests
  input  wire logic slow,
  input  wire logic ch0_transfer_req,
  input  wire logic ch1_transfer_req,
  // Byte strobes back to the block
  output logic      ch0_byte_moved,
  output logic      ch1_byte_moved
);
  logic [1:0] pace;

  // Strobes may trail a finished transfer by up to two cycles; the block must ignore those.
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
    begin
      pace           <= 2'h0;
      ch0_byte_moved <= 1'h0;
      ch1_byte_moved <= 1'h0;
    end
    else
    begin
      pace           <= pace + 2'h1;
      ch0_byte_moved <= ch0_transfer_req && (!slow || pace == 2'h0);
      ch1_byte_moved <= ch1_transfer_req && (!slow || pace == 2'h0);
    end
endmodule : dma_bus_sequencer_model

/* tb/dual_channel_dma_regs_enable_tb.sv */
/*
  Self-checking bench for the two-channel DMA register block.
  Assumes the sequencer model and the checker in tb/.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end

module dual_channel_dma_regs_enable_tb;
  logic        sys_clk, arst_n, io_wr, io_rd, nmi_pulse, slow, serial0_tx_request;
  logic        external_request_in, serial1_tx_request;
  logic        ch0_active, ch1_active, ch0_transfer_req, ch1_transfer_req;
  logic        ch0_irq, ch1_irq, ch0_byte_moved, ch1_byte_moved;
  logic [7:0]  io_addr, io_wdata, io_rdata, ch1_request_select_byte;
  logic [1:0]  ch0_dest_step, ch1_memory_step;
  logic [19:0] ch0_dest_address, ch1_memory_address;
  logic [15:0] ch1_io_address;
  int          mismatches, checks_done, n;
  // Rows: offset, written byte, expected read; bank bytes keep only their low nibble.
  localparam logic [23:0] rows [15] = '{24'h235A5A, 24'h24C3C3, 24'h25A505, 24'h26FFFF,
    24'h278080, 24'h281212, 24'h293434, 24'h2AF707, 24'h2B9E9E, 24'h2C6161, 24'h2DFFFF,
    24'h2E0101, 24'h2F0000, 24'h227700, 24'h31FF00};

  dual_channel_dma_regs_enable uut
  (
    .sys_clk, .arst_n, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata, .nmi_pulse,
    .external_request_in, .external_request_in1(1'h0), .serial0_tx_request,
    .serial1_tx_request, .ch0_byte_moved, .ch1_byte_moved, .ch0_dest_step,
    .ch1_memory_step, .ch0_active, .ch1_active, .ch0_transfer_req, .ch1_transfer_req,
    .ch0_dest_address, .ch1_memory_address, .ch1_io_address, .ch1_request_select_byte,
    .ch0_irq, .ch1_irq
  );

  dma_bus_sequencer_model model
  (
    .sys_clk, .arst_n, .slow, .ch0_transfer_req, .ch1_transfer_req, .ch0_byte_moved, .ch1_byte_moved
  );

  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic bounded(input int cnt);
    if (cnt >= 2000)
    begin
      mismatches++;
      $display("FAIL %0t wait ran out", $time);
      complete_run();
    end
  endtask : bounded

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'h1;
    @(posedge sys_clk);
    io_wr <= 1'h0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd   <= 1'h1;
    @(posedge sys_clk);
    io_rd <= 1'h0;
    #1;
    `CHK(io_rdata, e)
  endtask : rdchk

  initial
  begin
    {arst_n, io_wr, io_rd, nmi_pulse, serial0_tx_request} = 5'h00;
    {io_addr, io_wdata} = 16'h0000;
    {external_request_in, serial1_tx_request} = 2'h0;
    {ch0_dest_step, ch1_memory_step, slow} = 5'h0B;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'h1;
    rdchk(8'h30, 8'h30);
    rdchk(8'h2D, 8'h00);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdchk(rows[i][23:16], rows[i][7:0]);
    end
    $display("register table test done");
    // Channel 0: 257 bytes so the count borrows across its byte boundary.
    wr(8'h23, 8'h00);
    wr(8'h24, 8'h10);
    wr(8'h25, 8'h01);
    wr(8'h26, 8'h01);
    wr(8'h27, 8'h01);
    serial0_tx_request <= 1'h1;
    wr(8'h30, 8'h64);
    for (n = 0; n < 2000 && ch0_irq !== 1'h1; n++) @(negedge sys_clk);
    bounded(n);
    rdchk(8'h26, 8'h00);
    rdchk(8'h27, 8'h00);
    rdchk(8'h23, 8'h01);
    rdchk(8'h24, 8'h11);
    rdchk(8'h30, 8'h35);
    `CHK(ch0_active, 1'h0)
    `CHK(ch0_dest_address, 20'h11101)
    $display("channel 0 transfer test done");
    // Main enable is 1 here, so writing its bit as 0 shows that direct writes are ignored.
    wr(8'h30, 8'h70);
    rdchk(8'h30, 8'h31);
    `CHK(ch0_irq, 1'h0)
    $display("guarded write test done");
    slow <= 1'h0;
    serial0_tx_request <= 1'h0;
    wr(8'h28, 8'h10);
    wr(8'h2E, 8'h05);
    wr(8'h2F, 8'h00);
    wr(8'h2D, 8'h01);
    wr(8'h30, 8'h90);
    rdchk(8'h30, 8'hB1);
    `CHK(ch1_active, 1'h1)
    `CHK(ch1_request_select_byte, 8'h01)
    @(posedge sys_clk);
    nmi_pulse <= 1'h1;
    @(posedge sys_clk);
    nmi_pulse <= 1'h0;
    serial0_tx_request <= 1'h1;
    wr(8'h30, 8'h31);
    rdchk(8'h30, 8'hB0);
    `CHK(ch1_active, 1'h0)
    rdchk(8'h2E, 8'h05);
    wr(8'h30, 8'h90);
    @(negedge sys_clk);
    for (n = 0; n < 2000 && ch1_active !== 1'h1; n++) @(negedge sys_clk);
    bounded(n);
    `CHK(ch1_transfer_req, 1'h1)
    for (n = 0; n < 2000 && ch1_active !== 1'h0; n++) @(negedge sys_clk);
    bounded(n);
    rdchk(8'h2E, 8'h00);
    rdchk(8'h28, 8'h15);
    rdchk(8'h30, 8'h31);
    `CHK(ch1_irq, 1'h0)
    `CHK(ch1_memory_address, 20'h73415)
    `CHK(ch1_io_address, 16'h619E)
    $display("nmi and restart test done");
    // With every request line high, the unused source code must never raise a request.
    @(posedge sys_clk);
    external_request_in <= 1'h1;
    serial1_tx_request  <= 1'h1;
    ch0_dest_step       <= 2'h2;
    wr(8'h25, 8'h03);
    wr(8'h26, 8'h01);
    wr(8'h27, 8'h00);
    wr(8'h30, 8'h60);
    repeat (3) @(negedge sys_clk);
    `CHK(ch0_active, 1'h1)
    `CHK(ch0_transfer_req, 1'h0)
    rdchk(8'h26, 8'h01);
    // Only the external pin stays high, so the byte moved here proves that source path.
    @(posedge sys_clk);
    serial0_tx_request <= 1'h0;
    serial1_tx_request <= 1'h0;
    wr(8'h25, 8'h00);
    for (n = 0; n < 2000 && ch0_active !== 1'h0; n++) @(negedge sys_clk);
    bounded(n);
    rdchk(8'h26, 8'h00);
    `CHK(ch0_dest_address, 20'h01100)
    $display("source select test done");
    wr(8'h30, 8'h8C);
    rdchk(8'h30, 8'hBD);
    `CHK(ch0_irq, 1'h1)
    `CHK(ch1_irq, 1'h0)
    @(posedge sys_clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'h1;
    rdchk(8'h30, 8'h30);
    rdchk(8'h2D, 8'h00);
    `CHK(ch0_irq, 1'h0)
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : dual_channel_dma_regs_enable_tb

bind dual_channel_dma_regs_enable dual_channel_dma_regs_enable_asserts checker_inst
(
  .sys_clk, .arst_n, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata, .nmi_pulse, .ch0_active,
  .ch1_active, .ch0_transfer_req, .ch0_dest_address, .ch1_request_select_byte, .ch0_irq
);
